// [src/err_regs_pkg.sv]
// constants for the error reporting register bank: register indices,
// field layouts, reset values and bus answers.
// assumes a 32-bit configuration bus where byte address = 4 * index.
package err_regs_pkg;
	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] CHASSIS_IDX = 10'h0A3;
	localparam logic [9:0] CAP_HDR_IDX = 10'h100;
	localparam logic [9:0] FATAL_STAT_IDX = 10'h104;
	localparam logic [9:0] FATAL_MASK_IDX = 10'h108;
	localparam logic [9:0] FATAL_SEV_IDX = 10'h10C;
	localparam logic [9:0] SOFT_STAT_IDX = 10'h110;
	localparam logic [9:0] SOFT_MASK_IDX = 10'h114;
	localparam logic [9:0] ERR_CTRL_IDX = 10'h118;
	localparam logic [9:0] HDR_LOG_IDX = 10'h11C;
	localparam logic [9:0] SEC_STAT_IDX = 10'h12C;
	localparam logic [9:0] SEC_MASK_IDX = 10'h130;
	localparam logic [9:0] IRQ_STAT_IDX = 10'h140;
	localparam logic [9:0] IRQ_CLR_IDX = 10'h141;
	localparam logic [9:0] IRQ_EN_IDX = 10'h142;
	localparam int ADDR_W = 12;
	localparam int HDR_WORDS = 4;
	// ==========================================================
	// field layouts and reset values
	localparam logic [31:0] CAP_HDR_VAL = 32'h1501_0001;
	localparam logic [31:0] FATAL_BITS = 32'h001F_F011;
	localparam logic [31:0] FATAL_SEV_RST = 32'h0006_2011;
	localparam logic [31:0] SOFT_BITS = 32'h0000_11C1;
	localparam logic [31:0] SEC_BITS = 32'h0000_3FEF;
	localparam logic [31:0] SEC_MASK_RST = 32'h0000_17A8;
	localparam logic [31:0] ZERO_W = 32'h0000_0000;
	localparam int CHASSIS_W = 8;
	localparam int FEP_W = 5;
	localparam int GEN_CAP_BIT = 5;
	localparam int GEN_EN_BIT = 6;
	localparam int CHK_CAP_BIT = 7;
	localparam int CHK_EN_BIT = 8;
	localparam int SEC_SERR_BIT = 12;
	localparam int SEC_W = 14;
	localparam int IRQ_W = 4;
	localparam int IRQ_FATAL = 0;
	localparam int IRQ_NONFATAL = 1;
	localparam int IRQ_SOFT = 2;
	localparam int IRQ_SEC = 3;
	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : err_regs_pkg

// [src/error_report_regs.sv]
// error reporting register bank of the bridge, behind an AXI4-Lite slave.
// assumes error detectors pulse one event bit per cycle per error and
// present the packet header with them; sticky fields follow aux_resetn.
// Summary of operation
// - 8-bit read/write chassis number, reset zero
// - capability header reads fixed id, version, next
// - uncorrectable status flags, write one clears
// - sticky uncorrectable mask bits, reset zero
// - sticky severity bits with documented mixed defaults
// - sticky correctable status flags, write one clears
// - sticky correctable mask bits, reset zero
// - sticky first error pointer, read only
// - ecrc generation capable, sticky generation enable
// - ecrc check capable, sticky check enable
// - sticky 128-bit header log of erroring packet
// - sticky secondary status bits 0-13, bit 4 zero
// - secondary serr assertion records no header
// - sticky secondary mask with documented defaults
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module error_report_regs (
	// clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic aux_resetn,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// error events from the detectors
	input wire logic [31:0] fatal_event,
	input wire logic [31:0] soft_event,
	input wire logic [13:0] sec_event,
	input wire logic [127:0] pkt_header,
	// controls and interrupt
	output logic ecrc_gen_en,
	output logic ecrc_chk_en,
	output logic irq
);
	// ==========================================================
	// helpers
	function automatic logic [4:0] first_bit(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : first_bit

	function automatic logic [9:0] idx_of(input logic [11:0] a);
		return a[11:2];
	endfunction : idx_of

	function automatic logic mapped(input logic [9:0] i);
		return i == err_regs_pkg::CHASSIS_IDX || (i >= err_regs_pkg::CAP_HDR_IDX &&
			i <= err_regs_pkg::SEC_MASK_IDX && !(i[1:0] != 2'h0 && i < err_regs_pkg::HDR_LOG_IDX)
			&& !(i > err_regs_pkg::HDR_LOG_IDX + 10'(err_regs_pkg::HDR_WORDS - 1)
			&& i < err_regs_pkg::SEC_STAT_IDX) && !(i > err_regs_pkg::SEC_STAT_IDX && i[1:0] != 2'h0))
			|| (i >= err_regs_pkg::IRQ_STAT_IDX && i <= err_regs_pkg::IRQ_EN_IDX);
	endfunction : mapped

	// ==========================================================
	// bus slave state
	logic aw_v_q, w_v_q, bvalid_q, rvalid_q;
	logic [9:0] aw_idx_q, rd_idx_q;
	logic [31:0] wdata_q, rdata_q, rdata_d;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	wire logic rst_any = !aresetn || !aux_resetn;
	wire logic wr_go = aw_v_q && w_v_q && !bvalid_q;
	wire logic rd_go = arvalid && !rvalid_q;
	wire logic [9:0] rd_idx = idx_of(araddr);
	wire logic [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire logic [31:0] wbits = wdata_q & bmask;

	assign awready = !aw_v_q;
	assign wready = !w_v_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_v_q <= 1'b0;
			w_v_q <= 1'b0;
			bvalid_q <= 1'b0;
			aw_idx_q <= 10'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bresp_q <= err_regs_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_v_q <= 1'b1;
				aw_idx_q <= idx_of(awaddr);
			end else if (wr_go) begin
				aw_v_q <= 1'b0;
			end
			if (wvalid && wready) begin
				w_v_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end else if (wr_go) begin
				w_v_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= mapped(aw_idx_q) ? err_regs_pkg::RESP_OKAY : err_regs_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rd_idx_q <= 10'h000;
			rdata_q <= 32'h0000_0000;
			rresp_q <= err_regs_pkg::RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rd_idx_q <= rd_idx;
			rdata_q <= rdata_d;
			rresp_q <= mapped(rd_idx) ? err_regs_pkg::RESP_OKAY : err_regs_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// register storage
	logic [7:0] chassis_q;
	logic [31:0] fatal_stat_q, fatal_mask_q, fatal_sev_q;
	logic [31:0] soft_stat_q, soft_mask_q, sec_stat_q, sec_mask_q;
	logic [4:0] fep_q;
	logic gen_en_q, chk_en_q;
	logic [127:0] hdr_q;
	logic [3:0] irq_stat_q, irq_en_q;

	function automatic logic wr_at(input logic [9:0] i);
		return wr_go && aw_idx_q == i;
	endfunction : wr_at

	function automatic logic [31:0] rw_merge(input logic [31:0] q, input logic [31:0] w,
		input logic [31:0] m, input logic [31:0] bm);
		return (q & ~(bm & m)) | (w & bm & m);
	endfunction : rw_merge

	// chassis number merged through the byte strobes
	wire logic [31:0] chassis_new = rw_merge({24'h000000, chassis_q}, wdata_q,
		32'h0000_00FF, bmask);

	// event qualification and logging
	wire logic [31:0] fatal_ev = fatal_event & err_regs_pkg::FATAL_BITS;
	wire logic [31:0] soft_ev = soft_event & err_regs_pkg::SOFT_BITS;
	wire logic [31:0] sec_ev = {18'h00000, sec_event} & err_regs_pkg::SEC_BITS;
	wire logic [31:0] fatal_live = fatal_ev & ~fatal_mask_q;
	wire logic [31:0] sec_live = sec_ev & ~sec_mask_q;
	wire logic [31:0] sec_loggable = sec_live & ~(32'h1 << err_regs_pkg::SEC_SERR_BIT);
	wire logic log_busy = |(fatal_stat_q & ~fatal_mask_q) ||
		|(sec_stat_q & ~sec_mask_q & ~(32'h1 << err_regs_pkg::SEC_SERR_BIT));
	wire logic log_take = !log_busy && (|fatal_live || |sec_loggable);
	wire logic fep_take = !log_busy && |fatal_live;
	wire logic [3:0] irq_ev = {|sec_live, |(soft_ev & ~soft_mask_q),
		|(fatal_live & ~fatal_sev_q), |(fatal_live & fatal_sev_q)};

	// non-sticky fields: any reset
	always_ff @(posedge aclk) begin
		if (rst_any) begin
			chassis_q <= 8'h00;
			fatal_stat_q <= 32'h0000_0000;
			irq_stat_q <= 4'h0;
			irq_en_q <= 4'h0;
		end else begin
			if (wr_at(err_regs_pkg::CHASSIS_IDX)) begin
				chassis_q <= chassis_new[err_regs_pkg::CHASSIS_W-1:0];
			end
			fatal_stat_q <= (fatal_stat_q & ~(wr_at(err_regs_pkg::FATAL_STAT_IDX) ? wbits
				: 32'h0000_0000)) | fatal_ev;
			irq_stat_q <= (irq_stat_q & ~(wr_at(err_regs_pkg::IRQ_CLR_IDX) ? wbits[3:0]
				: 4'h0)) | irq_ev;
			if (wr_at(err_regs_pkg::IRQ_EN_IDX)) begin
				irq_en_q <= wbits[3:0] | (irq_en_q & ~bmask[3:0]);
			end
		end
	end

	// sticky fields: auxiliary reset only
	always_ff @(posedge aclk) begin
		if (!aux_resetn) begin
			fatal_mask_q <= err_regs_pkg::ZERO_W;
			fatal_sev_q <= err_regs_pkg::FATAL_SEV_RST;
			soft_stat_q <= err_regs_pkg::ZERO_W;
			soft_mask_q <= err_regs_pkg::ZERO_W;
			sec_stat_q <= err_regs_pkg::ZERO_W;
			sec_mask_q <= err_regs_pkg::SEC_MASK_RST;
			fep_q <= 5'h00;
			gen_en_q <= 1'b0;
			chk_en_q <= 1'b0;
			hdr_q <= 128'h0;
		end else begin
			if (wr_at(err_regs_pkg::FATAL_MASK_IDX)) begin
				fatal_mask_q <= rw_merge(fatal_mask_q, wdata_q, err_regs_pkg::FATAL_BITS, bmask);
			end
			if (wr_at(err_regs_pkg::FATAL_SEV_IDX)) begin
				fatal_sev_q <= rw_merge(fatal_sev_q, wdata_q, err_regs_pkg::FATAL_BITS, bmask);
			end
			if (wr_at(err_regs_pkg::SOFT_MASK_IDX)) begin
				soft_mask_q <= rw_merge(soft_mask_q, wdata_q, err_regs_pkg::SOFT_BITS, bmask);
			end
			if (wr_at(err_regs_pkg::SEC_MASK_IDX)) begin
				sec_mask_q <= rw_merge(sec_mask_q, wdata_q, err_regs_pkg::SEC_BITS, bmask);
			end
			soft_stat_q <= (soft_stat_q & ~(wr_at(err_regs_pkg::SOFT_STAT_IDX) ? wbits
				: 32'h0000_0000)) | soft_ev;
			sec_stat_q <= (sec_stat_q & ~(wr_at(err_regs_pkg::SEC_STAT_IDX) ? wbits
				: 32'h0000_0000)) | sec_ev;
			if (wr_at(err_regs_pkg::ERR_CTRL_IDX) && bmask[err_regs_pkg::GEN_EN_BIT]) begin
				gen_en_q <= wdata_q[err_regs_pkg::GEN_EN_BIT];
			end
			if (wr_at(err_regs_pkg::ERR_CTRL_IDX) && bmask[err_regs_pkg::CHK_EN_BIT]) begin
				chk_en_q <= wdata_q[err_regs_pkg::CHK_EN_BIT];
			end
			if (fep_take) begin
				fep_q <= first_bit(fatal_live);
			end
			if (log_take) begin
				hdr_q <= pkt_header;
			end
		end
	end

	assign ecrc_gen_en = gen_en_q;
	assign ecrc_chk_en = chk_en_q;
	assign irq = |(irq_stat_q & irq_en_q);

	// ==========================================================
	// read data selection
	wire logic [31:0] ctrl_word = {23'h000000, chk_en_q, 1'b1, gen_en_q, 1'b1, fep_q};
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (rd_idx)
			err_regs_pkg::CHASSIS_IDX: rdata_d = {24'h000000, chassis_q};
			err_regs_pkg::CAP_HDR_IDX: rdata_d = err_regs_pkg::CAP_HDR_VAL;
			err_regs_pkg::FATAL_STAT_IDX: rdata_d = fatal_stat_q;
			err_regs_pkg::FATAL_MASK_IDX: rdata_d = fatal_mask_q;
			err_regs_pkg::FATAL_SEV_IDX: rdata_d = fatal_sev_q;
			err_regs_pkg::SOFT_STAT_IDX: rdata_d = soft_stat_q;
			err_regs_pkg::SOFT_MASK_IDX: rdata_d = soft_mask_q;
			err_regs_pkg::ERR_CTRL_IDX: rdata_d = ctrl_word;
			err_regs_pkg::HDR_LOG_IDX: rdata_d = hdr_q[31:0];
			err_regs_pkg::HDR_LOG_IDX + 10'h001: rdata_d = hdr_q[63:32];
			err_regs_pkg::HDR_LOG_IDX + 10'h002: rdata_d = hdr_q[95:64];
			err_regs_pkg::HDR_LOG_IDX + 10'h003: rdata_d = hdr_q[127:96];
			err_regs_pkg::SEC_STAT_IDX: rdata_d = sec_stat_q;
			err_regs_pkg::SEC_MASK_IDX: rdata_d = sec_mask_q;
			err_regs_pkg::IRQ_STAT_IDX: rdata_d = {28'h0000000, irq_stat_q};
			err_regs_pkg::IRQ_EN_IDX: rdata_d = {28'h0000000, irq_en_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !aux_resetn);

	sequence rd_of(logic [9:0] i);
		rd_go && rd_idx == i;
	endsequence

	sequence wr_one_at(logic [9:0] i);
		wr_go && aw_idx_q == i && wstrb_q == 4'hF;
	endsequence

	cap_header_a: assert property (rd_of(err_regs_pkg::CAP_HDR_IDX) |=> rdata == 32'h1501_0001)
		else $error("capability header read wrong");
	ecrc_caps_a: assert property (rd_of(err_regs_pkg::ERR_CTRL_IDX) |=> rdata[5] && rdata[7])
		else $error("ecrc capable bits not set");
	fatal_set_a: assert property (fatal_event[14] |=> fatal_stat_q[14])
		else $error("uncorrectable status not set by event");
	fatal_clear_a: assert property (wr_one_at(err_regs_pkg::FATAL_STAT_IDX) ##0 (wdata_q[14]
		&& !fatal_event[14]) |=> !fatal_stat_q[14])
		else $error("uncorrectable status not cleared by one");
	sec_reserved_a: assert property (sec_event[4] |=> !sec_stat_q[4])
		else $error("reserved secondary bit set");
	serr_no_log_a: assert property (sec_event == 14'h1000 && fatal_event == 32'h0
		|=> $stable(hdr_q))
		else $error("header logged for serr assertion");
	fep_track_a: assert property (fep_take && fatal_live[13:0] == 14'h0 && fatal_live[15:14] == 2'h1
		|=> fep_q == 5'd14 && hdr_q == $past(pkt_header))
		else $error("first error pointer or log wrong");
	chassis_rw_a: assert property (wr_one_at(err_regs_pkg::CHASSIS_IDX)
		|=> chassis_q == $past(wdata_q[7:0]))
		else $error("chassis number not written");
	sticky_hold_a: assert property (@(posedge aclk) disable iff (!aux_resetn)
		!aresetn && soft_event == 32'h0 |=> soft_stat_q == $past(soft_stat_q)
		&& sec_mask_q == $past(sec_mask_q))
		else $error("sticky field lost on functional reset");
	aux_defaults_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aux_resetn |=> fatal_sev_q == 32'h0006_2011
		&& sec_mask_q == 32'h0000_17A8 && fatal_mask_q == 32'h0 && soft_mask_q == 32'h0)
		else $error("sticky defaults wrong after aux reset");
	write_resp_a: assert property (wr_go |=> bvalid)
		else $error("write response missing");

	// answers stand until the master takes them
	sequence resp_waiting;
		bvalid && !bready;
	endsequence

	sequence data_waiting;
		rvalid && !rready;
	endsequence

	resp_hold_a: assert property (resp_waiting |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	read_hold_a: assert property (data_waiting |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped early");
	unmapped_rd_a: assert property (rd_of(10'h001) |=> rresp == err_regs_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");

	// register writes land in the next cycle
	mask_write_a: assert property (wr_one_at(err_regs_pkg::FATAL_MASK_IDX)
		|=> fatal_mask_q == ($past(wdata_q) & err_regs_pkg::FATAL_BITS))
		else $error("uncorrectable mask write wrong");
	sev_write_a: assert property (wr_one_at(err_regs_pkg::FATAL_SEV_IDX)
		|=> fatal_sev_q == ($past(wdata_q) & err_regs_pkg::FATAL_BITS))
		else $error("severity write wrong");
	soft_mask_write_a: assert property (wr_one_at(err_regs_pkg::SOFT_MASK_IDX)
		|=> soft_mask_q == ($past(wdata_q) & err_regs_pkg::SOFT_BITS))
		else $error("correctable mask write wrong");
	sec_mask_write_a: assert property (wr_one_at(err_regs_pkg::SEC_MASK_IDX)
		|=> sec_mask_q == ($past(wdata_q) & err_regs_pkg::SEC_BITS))
		else $error("secondary mask write wrong");
	ecrc_write_a: assert property (wr_one_at(err_regs_pkg::ERR_CTRL_IDX)
		|=> ecrc_gen_en == $past(wdata_q[6]) && ecrc_chk_en == $past(wdata_q[8]))
		else $error("ecrc enable write wrong");

	// event capture, clearing and interrupt
	soft_set_a: assert property (soft_event[6] |=> soft_stat_q[6])
		else $error("correctable status not set by event");
	soft_clear_a: assert property (wr_one_at(err_regs_pkg::SOFT_STAT_IDX) ##0
		(wdata_q[6] && !soft_event[6]) |=> !soft_stat_q[6])
		else $error("correctable status not cleared by one");
	sec_set_a: assert property (sec_event[13] |=> sec_stat_q[13])
		else $error("secondary status not set by event");
	sec_clear_a: assert property (wr_one_at(err_regs_pkg::SEC_STAT_IDX) ##0
		(wdata_q[13] && !sec_event[13]) |=> !sec_stat_q[13])
		else $error("secondary status not cleared by one");
	log_hold_a: assert property (log_busy |=> $stable(hdr_q))
		else $error("header log overwritten while error outstanding");
	irq_raise_a: assert property (|(irq_ev & irq_en_q) |=> irq)
		else $error("enabled event raised no interrupt");
	irq_clear_a: assert property (wr_one_at(err_regs_pkg::IRQ_CLR_IDX) ##0
		(wdata_q[3:0] == 4'hF && irq_ev == 4'h0) |=> !irq)
		else $error("interrupt not cleared");
endmodule : error_report_regs
`default_nettype wire

// [verification/test_advanced_error_reporting_regs.sv]
// self-checking bench for the error reporting register bank.
// assumes the bank alone on its AXI4-Lite bus and detectors driven here.
`timescale 1ns/1ps
`default_nettype none
module test_advanced_error_reporting_regs;
	// ==========================================================
	// clock, reset and design ports
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic aux_resetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ecrc_gen_en, ecrc_chk_en, irq;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] fatal_event = 32'h0000_0000;
	logic [31:0] soft_event = 32'h0000_0000;
	logic [31:0] rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [13:0] sec_event = 14'h0000;
	logic [127:0] pkt_header = 128'h0;
	localparam logic [127:0] HDR_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
	int err_count = 0;
	int samples_checked = 0;

	always #5 aclk = ~aclk;

	error_report_regs DUT (
		.aclk(aclk), .aresetn(aresetn), .aux_resetn(aux_resetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.fatal_event(fatal_event), .soft_event(soft_event), .sec_event(sec_event),
		.pkt_header(pkt_header), .ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en),
		.irq(irq)
	);

	// ==========================================================
	// verdict, comparison and bus tasks
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(inout int n);
		n++;
		if (n > 100) begin
			err_count++;
			$display("CHECK FAILED at %0t: no handshake", $time);
			end_of_test();
		end
	endtask : tick

	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic a;
		logic w;
		n = 0;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(negedge aclk);
			tick(n);
			a = a | awready;
			w = w | wready;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		do begin
			@(negedge aclk);
			tick(n);
		end while (bvalid !== 1'b1);
		check({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			tick(n);
		end while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			tick(n);
		end while (rvalid !== 1'b1);
		check(rdata, exp);
		check({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	// one-cycle event pulse with its packet header
	task automatic pulse(input logic [31:0] f, input logic [31:0] s, input logic [13:0] e,
		input logic [127:0] h);
		@(posedge aclk);
		fatal_event <= f;
		soft_event <= s;
		sec_event <= e;
		pkt_header <= h;
		@(posedge aclk);
		fatal_event <= 32'h0000_0000;
		soft_event <= 32'h0000_0000;
		sec_event <= 14'h0000;
	endtask : pulse

	task automatic chk_irq(input logic exp);
		@(negedge aclk);
		check({31'h0, irq}, {31'h0, exp});
	endtask : chk_irq

	// aux high also drops the power-on reset
	task automatic do_reset(input logic aux);
		@(posedge aclk);
		aresetn <= 1'b0;
		aux_resetn <= ~aux;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		aux_resetn <= 1'b1;
	endtask : do_reset

	// ==========================================================
	// scenarios
	task automatic sc_defaults();
		logic [9:0] ix [14];
		logic [31:0] v [14];
		ix = '{10'h0A3, 10'h100, 10'h104, 10'h108, 10'h10C, 10'h110, 10'h114,
			10'h118, 10'h11C, 10'h11D, 10'h11E, 10'h11F, 10'h12C, 10'h130};
		v = '{32'h0, 32'h1501_0001, 32'h0, 32'h0, 32'h0006_2011, 32'h0, 32'h0,
			32'h0000_00A0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_17A8};
		for (int i = 0; i < 14; i++) begin
			rd(ix[i], v[i], 2'h0);
		end
	endtask : sc_defaults

	task automatic sc_access();
		wr(10'h0A3, 32'hFFFF_FFA5, 2'h0);
		rd(10'h0A3, 32'h0000_00A5, 2'h0);
		wr(10'h100, 32'h0000_0000, 2'h0);
		rd(10'h100, 32'h1501_0001, 2'h0);
		wr(10'h108, 32'hFFFF_FFFF, 2'h0);
		rd(10'h108, 32'h001F_F011, 2'h0);
		wr(10'h10C, 32'hFFFF_FFFF, 2'h0);
		rd(10'h10C, 32'h001F_F011, 2'h0);
		wr(10'h114, 32'hFFFF_FFFF, 2'h0);
		rd(10'h114, 32'h0000_11C1, 2'h0);
		wr(10'h130, 32'hFFFF_FFFF, 2'h0);
		rd(10'h130, 32'h0000_3FEF, 2'h0);
		wr(10'h118, 32'hFFFF_FFFF, 2'h0);
		rd(10'h118, 32'h0000_01E0, 2'h0);
		check({30'h0, ecrc_gen_en, ecrc_chk_en}, 32'h0000_0003);
		wr(10'h11C, 32'hFFFF_FFFF, 2'h0);
		rd(10'h11C, 32'h0000_0000, 2'h0);
		pulse(32'h0, 32'hFFFF_FFFF, 14'h0000, 128'h0);
		rd(10'h110, 32'h0000_11C1, 2'h0);
		wr(10'h110, 32'h0000_0040, 2'h0);
		rd(10'h110, 32'h0000_1181, 2'h0);
		wr(10'h001, 32'hFFFF_FFFF, 2'h2);
		rd(10'h001, 32'h0000_0000, 2'h2);
	endtask : sc_access

	// functional reset keeps sticky fields, power-on reset restores all
	task automatic sc_sticky();
		do_reset(1'b0);
		rd(10'h0A3, 32'h0000_0000, 2'h0);
		rd(10'h108, 32'h001F_F011, 2'h0);
		rd(10'h10C, 32'h001F_F011, 2'h0);
		rd(10'h110, 32'h0000_1181, 2'h0);
		rd(10'h118, 32'h0000_01E0, 2'h0);
		rd(10'h130, 32'h0000_3FEF, 2'h0);
		do_reset(1'b1);
		sc_defaults();
	endtask : sc_sticky

	task automatic sc_fatal();
		wr(10'h142, 32'h0000_000F, 2'h0);
		pulse(32'h0000_5000, 32'h0, 14'h0000, HDR_A);
		rd(10'h104, 32'h0000_5000, 2'h0);
		rd(10'h118, 32'h0000_00AC, 2'h0);
		for (int i = 0; i < 4; i++) begin
			rd(10'h11C + 10'(i), HDR_A[32*i +: 32], 2'h0);
		end
		chk_irq(1'b1);
		rd(10'h140, 32'h0000_0002, 2'h0);
		wr(10'h104, 32'h0000_1000, 2'h0);
		rd(10'h104, 32'h0000_4000, 2'h0);
		wr(10'h104, 32'h0000_4000, 2'h0);
		wr(10'h141, 32'h0000_0002, 2'h0);
		rd(10'h140, 32'h0000_0000, 2'h0);
		chk_irq(1'b0);
		pulse(32'h0000_4000, 32'h0, 14'h0000, HDR_A);
		rd(10'h118, 32'h0000_00AE, 2'h0);
		wr(10'h104, 32'h0000_4000, 2'h0);
		wr(10'h141, 32'h0000_0002, 2'h0);
		chk_irq(1'b0);
	endtask : sc_fatal

	task automatic sc_secondary();
		wr(10'h130, 32'h0000_0000, 2'h0);
		wr(10'h142, 32'h0000_0000, 2'h0);
		pulse(32'h0, 32'h0, 14'h1000, ~HDR_A);
		rd(10'h12C, 32'h0000_1000, 2'h0);
		rd(10'h11C, HDR_A[31:0], 2'h0);
		chk_irq(1'b0);
		rd(10'h140, 32'h0000_0008, 2'h0);
		wr(10'h142, 32'h0000_0008, 2'h0);
		chk_irq(1'b1);
		pulse(32'h0, 32'h0, 14'h3FFF, HDR_A);
		rd(10'h12C, 32'h0000_3FEF, 2'h0);
		wr(10'h12C, 32'hFFFF_FFFF, 2'h0);
		rd(10'h12C, 32'h0000_0000, 2'h0);
		wr(10'h141, 32'h0000_000F, 2'h0);
		chk_irq(1'b0);
	endtask : sc_secondary

	// ==========================================================
	// main sequence
	initial begin
		do_reset(1'b1);
		sc_defaults();
		sc_access();
		sc_sticky();
		sc_fatal();
		sc_secondary();
		end_of_test();
	end
endmodule : test_advanced_error_reporting_regs
`default_nettype wire
